// file: ubc_defines.svh
// Purpose: Constants of the boot loader and interrupt unit
// Assumes: 40 MHz system clock
// Notes:   Included by the design
`ifndef UBC_DEFINES_SVH
`define UBC_DEFINES_SVH

`define UBC_MARKER        8'hC4
`define UBC_DEFAULT_LEN   16'h0006
`define UBC_DESC_MAX      16'h01F4
`define UBC_STRAP_SINGLE  3'h0
`define UBC_STRAP_DOUBLE  3'h1
`define UBC_MEM_CTRL      4'hA

`define UBC_DESC_PORT     6'h30
`define UBC_MASK_REG      6'h31
`define UBC_IFCFG_REG     6'h32
`define UBC_POLAR_REG     6'h33

`define UBC_IFCFG_RST     8'h00
`define UBC_POLAR_RST     8'h00
`define UBC_MASK_RST      8'h00
`define UBC_MASK_USED     8'hE7

`define UBC_IRQ_SETUP     7
`define UBC_IRQ_CTRLBUF   6
`define UBC_IRQ_OUTFLAGS  5
`define UBC_IRQ_ENUMDONE  2
`define UBC_IRQ_BUSACT    1
`define UBC_IRQ_READY     0

`define UBC_PKT_HS        11'h200
`define UBC_PKT_FS        11'h040
`define UBC_EP_IN_MASK    4'hC

`define UBC_CLK_NS        25
`define UBC_I2C_QTR_NS    2500
`define UBC_QTR_CYC       ((`UBC_I2C_QTR_NS + `UBC_CLK_NS - 1) / `UBC_CLK_NS)

`endif

// file: ubc_pkg.sv
// Purpose: Types of the boot loader and interrupt unit
// Assumes: Nothing beyond the defines header
// Notes:   Constants live in ubc_defines.svh
package ubc_pkg;

  typedef enum logic [3:0] {
    L_STRAP  = 4'h0,
    L_START  = 4'h1,
    L_DEVW   = 4'h3,
    L_ADRH   = 4'h2,
    L_ADRL   = 4'h6,
    L_RSTART = 4'h7,
    L_DEVR   = 4'h5,
    L_READ   = 4'h4,
    L_FLUSH  = 4'hC,
    L_STOP   = 4'hD,
    L_HOST   = 4'hF,
    L_DONE   = 4'hE
  } ubc_load_t;

  typedef enum logic [1:0] {
    E_IDLE  = 2'h0,
    E_START = 2'h1,
    E_BITS  = 2'h3,
    E_STOP  = 2'h2
  } ubc_eng_t;

  typedef struct packed {
    logic setup;
    logic ctrl_buf;
    logic out_flags;
    logic enum_done;
    logic bus_act;
  } ubc_evt_t;

  typedef struct packed {
    logic [15:0] device_code;
    logic [15:0] product_code;
    logic [15:0] vendor_code;
  } ubc_ids_t;

endpackage : ubc_pkg

// file: ubc_boot_irq.sv
// Purpose: Power-up configuration loader and interrupt unit of a USB interface device
// Assumes: One clock, synchronous active-high reset, strobes synchronous and active high
// Notes:   Two-wire memory read by a bit engine with open-drain style enables
//
// Functional notes
// - Probe two-wire memory at power-up when strap is 000 or 001, boot from it
// - First marker valid: load interface config, polarity
// - Second marker: enumerate from memory descriptor
// - No second marker: wait for master descriptor
// - No memory: stay disconnected until descriptor given
// - Length from indices four, five, low first
// - Descriptors longer than 500 bytes rejected
// - Length six: load three identity codes, default
// - Strap 000 one address byte, 001 two
// - Default: EP2,4 bulk OUT, EP6,8 bulk IN
// - Six sources, each gated by mask bit
// - Enabled event asserts interrupt, sets status bit
// - Status byte read on low data lines
// - Status read clears interrupt and deasserts line
// - One interrupt shown at a time, rest queued
// - Hold interrupts while register read is pending
// - Interrupt signals register read data ready
// - Bits: setup7 ctrl6 out5 enum2 bus1 ready0
`include "ubc_defines.svh"

module ubc_boot_irq (
  input  wire logic             sys_clk,             // System clock
  input  wire logic             reset,               // Synchronous reset
  input  wire logic             scl_i,               // Serial clock line level
  output logic                  scl_o,               // Serial clock drive value
  output logic                  scl_oe,              // Serial clock pulled low
  input  wire logic             sda_i,               // Serial data line level
  output logic                  sda_o,               // Serial data drive value
  output logic                  sda_oe,              // Serial data pulled low
  input  wire logic [2:0]       memory_strap_bits,   // Memory address strap
  input  wire ubc_pkg::ubc_evt_t usb_evt,            // Event pulses from USB engine
  input  wire logic             high_speed,          // Link at high speed
  input  wire logic             cmd_wr,              // Command write strobe
  input  wire logic             cmd_rd_req,          // Register read request strobe
  input  wire logic [5:0]       cmd_addr,            // Command register address
  input  wire logic [7:0]       cmd_data,            // Command write data
  input  wire logic             slave_read_strobe,   // Read strobe
  input  wire logic             slave_output_enable, // Output enable
  output logic                  int_n,               // Interrupt, active low
  output logic                  ready_out,           // High while the interrupt signals read data ready, low once it is on the bus
  output logic [7:0]            data_bus_low_byte,   // Read data
  output logic                  data_bus_oe,         // Read data driven
  output logic [7:0]            interface_config,    // Interface configuration
  output logic [7:0]            flag_polarity,       // Flag polarity
  output logic                  desc_strobe,         // Descriptor byte valid
  output logic [7:0]            desc_byte,           // Descriptor byte
  output logic                  usb_connect,         // Attach and enumerate
  output logic                  default_desc,        // Use built-in descriptor
  output ubc_pkg::ubc_ids_t     id_codes,            // Identity codes
  output logic [10:0]           ep_pkt_size,         // Default packet size
  output logic [3:0]            ep_in_mask           // EP8,6,4,2 direction, 1 is IN
);

  localparam logic [7:0] QTR_LAST = 8'(`UBC_QTR_CYC - 1);

  // Bit engine
  ubc_pkg::ubc_eng_t eng_q, eng_d;
  logic [7:0] qcnt_q, qcnt_d;
  logic [1:0] qtr_q, qtr_d;
  logic [3:0] bit_q, bit_d;
  logic [8:0] tx_q, tx_d, rx_q, rx_d;
  logic       scl_oe_d, sda_oe_d, eng_done;
  logic       go;
  ubc_pkg::ubc_eng_t go_op;
  logic [8:0] go_tx;

  always_comb
  begin
    eng_d    = eng_q;
    qcnt_d   = qcnt_q;
    qtr_d    = qtr_q;
    bit_d    = bit_q;
    tx_d     = tx_q;
    rx_d     = rx_q;
    scl_oe_d = scl_oe;
    sda_oe_d = sda_oe;
    eng_done = 1'b0;
    if (eng_q == ubc_pkg::E_IDLE)
    begin
      if (go)
      begin
        eng_d  = go_op;
        qcnt_d = 8'h00;
        qtr_d  = 2'h0;
        bit_d  = 4'h0;
        tx_d   = go_tx;
      end
    end
    else
    begin
      case (eng_q)
        ubc_pkg::E_START:
        begin
          scl_oe_d = (qtr_q == 2'h0) || (qtr_q == 2'h3);
          sda_oe_d = qtr_q[1];
        end
        ubc_pkg::E_BITS:
        begin
          scl_oe_d = (qtr_q == 2'h0) || (qtr_q == 2'h3);
          sda_oe_d = ~tx_q[8];
        end
        default:
        begin
          scl_oe_d = (qtr_q == 2'h0);
          sda_oe_d = ~qtr_q[1];
        end
      endcase
      // Memory may stretch the clock: wait while it holds the line low
      if (!(qtr_q == 2'h1 && !scl_oe && !scl_i))
      begin
        qcnt_d = qcnt_q + 8'h01;
        if (qcnt_q == QTR_LAST)
        begin
          qcnt_d = 8'h00;
          qtr_d  = qtr_q + 2'h1;
          if (qtr_q == 2'h1 && eng_q == ubc_pkg::E_BITS)
            rx_d = {rx_q[7:0], sda_i};
          if (qtr_q == 2'h3)
          begin
            if (eng_q != ubc_pkg::E_BITS || bit_q == 4'h8)
            begin
              eng_d    = ubc_pkg::E_IDLE;
              eng_done = 1'b1;
            end
            else
            begin
              bit_d = bit_q + 4'h1;
              tx_d  = {tx_q[7:0], 1'b1};
            end
          end
        end
      end
    end
  end

  // Loader
  ubc_pkg::ubc_load_t ld_q, ld_d;
  logic [2:0]  strap_q, strap_d;
  logic        wait_q, wait_d;
  logic        memdesc_q, memdesc_d;
  logic [9:0]  idx_q, idx_d;
  logic [9:0]  pos_q, pos_d;
  logic [15:0] len_q, len_d;
  logic [47:0] ids_q, ids_d;
  logic [7:0]  ifcfg_d, polar_d;
  logic        feed, fin, ferr, desc_d, conn_d, dflt_d, boot_ready;
  logic [7:0]  fbyte;
  logic [15:0] pay_idx;

  always_comb
  begin
    ld_d       = ld_q;
    strap_d    = strap_q;
    wait_d     = wait_q;
    memdesc_d  = memdesc_q;
    idx_d      = idx_q;
    ifcfg_d    = interface_config;
    polar_d    = flag_polarity;
    go         = 1'b0;
    go_op      = ubc_pkg::E_BITS;
    go_tx      = 9'h1FF;
    feed       = 1'b0;
    fbyte      = rx_q[8:1];
    boot_ready = 1'b0;
    case (ld_q)
      ubc_pkg::L_START, ubc_pkg::L_RSTART: go_op = ubc_pkg::E_START;
      ubc_pkg::L_STOP:                     go_op = ubc_pkg::E_STOP;
      ubc_pkg::L_DEVW: go_tx = {`UBC_MEM_CTRL, strap_q, 1'b0, 1'b1};
      ubc_pkg::L_DEVR: go_tx = {`UBC_MEM_CTRL, strap_q, 1'b1, 1'b1};
      ubc_pkg::L_ADRH, ubc_pkg::L_ADRL: go_tx = 9'h001;
      ubc_pkg::L_READ: go_tx = 9'h1FE;
      default:         go_tx = 9'h1FF;
    endcase
    if (ld_q != ubc_pkg::L_STRAP && ld_q != ubc_pkg::L_HOST && ld_q != ubc_pkg::L_DONE)
    begin
      go     = !wait_q;
      wait_d = !eng_done;
    end
    case (ld_q)
      ubc_pkg::L_STRAP:
      begin
        strap_d = memory_strap_bits;
        if (memory_strap_bits == `UBC_STRAP_SINGLE || memory_strap_bits == `UBC_STRAP_DOUBLE)
          ld_d = ubc_pkg::L_START;
        else
        begin
          ld_d       = ubc_pkg::L_HOST;
          boot_ready = 1'b1;
        end
      end
      ubc_pkg::L_START:
        if (eng_done)
          ld_d = ubc_pkg::L_DEVW;
      ubc_pkg::L_DEVW:
        if (eng_done)
        begin
          if (rx_q[0])
            ld_d = ubc_pkg::L_STOP;
          else if (strap_q == `UBC_STRAP_DOUBLE)
            ld_d = ubc_pkg::L_ADRH;
          else
            ld_d = ubc_pkg::L_ADRL;
        end
      ubc_pkg::L_ADRH:
        if (eng_done)
          ld_d = ubc_pkg::L_ADRL;
      ubc_pkg::L_ADRL:
        if (eng_done)
          ld_d = ubc_pkg::L_RSTART;
      ubc_pkg::L_RSTART:
        if (eng_done)
          ld_d = ubc_pkg::L_DEVR;
      ubc_pkg::L_DEVR:
        if (eng_done)
        begin
          idx_d = 10'h000;
          ld_d  = rx_q[0] ? ubc_pkg::L_STOP : ubc_pkg::L_READ;
        end
      ubc_pkg::L_READ:
        if (eng_done)
        begin
          idx_d = idx_q + 10'h001;
          case (idx_q)
            10'h000: if (fbyte != `UBC_MARKER) ld_d = ubc_pkg::L_FLUSH;
            10'h001: ifcfg_d = fbyte;
            10'h002: polar_d = fbyte;
            10'h003: if (fbyte != `UBC_MARKER) ld_d = ubc_pkg::L_FLUSH;
            default:
            begin
              feed = 1'b1;
              if (fin)
              begin
                memdesc_d = 1'b1;
                ld_d      = ubc_pkg::L_FLUSH;
              end
              else if (ferr)
                ld_d = ubc_pkg::L_FLUSH;
            end
          endcase
        end
      ubc_pkg::L_FLUSH:
        if (eng_done)
          ld_d = ubc_pkg::L_STOP;
      ubc_pkg::L_STOP:
        if (eng_done)
        begin
          ld_d       = memdesc_q ? ubc_pkg::L_DONE : ubc_pkg::L_HOST;
          boot_ready = !memdesc_q;
        end
      ubc_pkg::L_HOST:
      begin
        feed  = cmd_wr && (cmd_addr == `UBC_DESC_PORT);
        fbyte = cmd_data;
        if (feed && fin)
          ld_d = ubc_pkg::L_DONE;
      end
      default: ld_d = ld_q;
    endcase
  end

  // Descriptor stage shared by memory and master: length low, length high, payload
  assign pay_idx = {6'h00, pos_q} - 16'h0002;

  always_comb
  begin
    pos_d  = pos_q;
    len_d  = len_q;
    ids_d  = ids_q;
    fin    = 1'b0;
    ferr   = 1'b0;
    desc_d = 1'b0;
    conn_d = usb_connect;
    dflt_d = default_desc;
    if (feed)
    begin
      pos_d = pos_q + 10'h001;
      if (pos_q == 10'h000)
        len_d[7:0] = fbyte;
      else if (pos_q == 10'h001)
      begin
        len_d[15:8] = fbyte;
        if ({fbyte, len_q[7:0]} == 16'h0000 || {fbyte, len_q[7:0]} > `UBC_DESC_MAX)
        begin
          ferr  = 1'b1;
          pos_d = 10'h000;
        end
      end
      else
      begin
        if (len_q == `UBC_DEFAULT_LEN)
          ids_d = {fbyte, ids_q[47:8]};
        else
          desc_d = 1'b1;
        if (pay_idx == len_q - 16'h0001)
        begin
          fin    = 1'b1;
          conn_d = 1'b1;
          dflt_d = (len_q == `UBC_DEFAULT_LEN);
        end
      end
    end
  end

  // Interrupt unit
  logic [7:0] ev, mask_q, mask_d, pend_q, pend_d, shown_q, shown_d, clr;
  logic [7:0] rdata_q, rdata_d, dout_d;
  logic       int_q, int_d, kind_q, kind_d, rdreq_q, rdreq_d, rd_prev_q, rd_edge;

  function automatic logic [7:0] top_bit(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      if (v[i])
        r = 8'h01 << i;
    return r;
  endfunction : top_bit

  function automatic logic [7:0] reg_value(input logic [5:0] a, input logic [7:0] m,
                                           input logic [7:0] c, input logic [7:0] p);
    case (a)
      `UBC_MASK_REG:  return m;
      `UBC_IFCFG_REG: return c;
      `UBC_POLAR_REG: return p;
      default:        return 8'h00;
    endcase
  endfunction : reg_value

  always_comb
  begin
    ev = 8'h00;
    ev[`UBC_IRQ_SETUP]    = usb_evt.setup;
    ev[`UBC_IRQ_CTRLBUF]  = usb_evt.ctrl_buf;
    ev[`UBC_IRQ_OUTFLAGS] = usb_evt.out_flags;
    ev[`UBC_IRQ_ENUMDONE] = usb_evt.enum_done;
    ev[`UBC_IRQ_BUSACT]   = usb_evt.bus_act;
    ev[`UBC_IRQ_READY]    = boot_ready;
    rd_edge = slave_read_strobe && !rd_prev_q && slave_output_enable;
    mask_d  = mask_q;
    if (cmd_wr && cmd_addr == `UBC_MASK_REG)
      mask_d = cmd_data & `UBC_MASK_USED;
    rdreq_d = rdreq_q;
    rdata_d = rdata_q;
    if (cmd_rd_req)
    begin
      rdreq_d = 1'b1;
      rdata_d = reg_value(cmd_addr, mask_q, interface_config, flag_polarity);
    end
    clr     = 8'h00;
    int_d   = int_q;
    kind_d  = kind_q;
    shown_d = shown_q;
    dout_d  = data_bus_low_byte;
    if (rd_edge)
    begin
      dout_d = 8'h00;
      if (int_q && kind_q)
      begin
        dout_d  = rdata_q;
        rdreq_d = cmd_rd_req;
      end
      else if (int_q)
      begin
        dout_d = shown_q;
        clr    = shown_q;
      end
      int_d   = 1'b0;
      kind_d  = 1'b0;
      shown_d = 8'h00;
    end
    else if (!int_q)
    begin
      if (rdreq_q)
      begin
        int_d  = 1'b1;
        kind_d = 1'b1;
      end
      else if (pend_q != 8'h00)
      begin
        int_d   = 1'b1;
        shown_d = top_bit(pend_q);
      end
    end
    pend_d = (pend_q & ~clr) | (ev & mask_q);
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      eng_q             <= ubc_pkg::E_IDLE;
      qcnt_q            <= 8'h00;
      qtr_q             <= 2'h0;
      bit_q             <= 4'h0;
      tx_q              <= 9'h1FF;
      rx_q              <= 9'h1FF;
      scl_oe            <= 1'b0;
      sda_oe            <= 1'b0;
      scl_o             <= 1'b0;
      sda_o             <= 1'b0;
      ld_q              <= ubc_pkg::L_STRAP;
      strap_q           <= 3'h0;
      wait_q            <= 1'b0;
      memdesc_q         <= 1'b0;
      idx_q             <= 10'h000;
      pos_q             <= 10'h000;
      len_q             <= 16'h0000;
      ids_q             <= 48'h0000_0000_0000;
      interface_config  <= `UBC_IFCFG_RST;
      flag_polarity     <= `UBC_POLAR_RST;
      desc_strobe       <= 1'b0;
      desc_byte         <= 8'h00;
      usb_connect       <= 1'b0;
      default_desc      <= 1'b0;
      id_codes          <= '0;
      ep_pkt_size       <= `UBC_PKT_FS;
      ep_in_mask        <= `UBC_EP_IN_MASK;
      mask_q            <= `UBC_MASK_RST;
      pend_q            <= 8'h00;
      shown_q           <= 8'h00;
      rdata_q           <= 8'h00;
      int_q             <= 1'b0;
      int_n             <= 1'b1;
      kind_q            <= 1'b0;
      ready_out         <= 1'b0;
      rdreq_q           <= 1'b0;
      rd_prev_q         <= 1'b0;
      data_bus_low_byte <= 8'h00;
      data_bus_oe       <= 1'b0;
    end
    else
    begin
      eng_q             <= eng_d;
      qcnt_q            <= qcnt_d;
      qtr_q             <= qtr_d;
      bit_q             <= bit_d;
      tx_q              <= tx_d;
      rx_q              <= rx_d;
      scl_oe            <= scl_oe_d;
      sda_oe            <= sda_oe_d;
      ld_q              <= ld_d;
      strap_q           <= strap_d;
      wait_q            <= wait_d;
      memdesc_q         <= memdesc_d;
      idx_q             <= idx_d;
      pos_q             <= pos_d;
      len_q             <= len_d;
      ids_q             <= ids_d;
      interface_config  <= ifcfg_d;
      flag_polarity     <= polar_d;
      desc_strobe       <= desc_d;
      desc_byte         <= fbyte;
      usb_connect       <= conn_d;
      default_desc      <= dflt_d;
      id_codes          <= ids_d;
      ep_pkt_size       <= high_speed ? `UBC_PKT_HS : `UBC_PKT_FS;
      mask_q            <= mask_d;
      pend_q            <= pend_d;
      shown_q           <= shown_d;
      rdata_q           <= rdata_d;
      int_q             <= int_d;
      int_n             <= ~int_d;
      kind_q            <= kind_d;
      ready_out         <= int_d && kind_d;
      rdreq_q           <= rdreq_d;
      rd_prev_q         <= slave_read_strobe;
      data_bus_low_byte <= dout_d;
      data_bus_oe       <= slave_output_enable;
    end
  end

endmodule : ubc_boot_irq

// file: ubc_mem_model.sv
// Purpose: Two-wire configuration memory seen by the boot loader
// Assumes: Pulled-up lines, one address byte, no clock stretching
// Notes:   Data is released whenever the model is not acking or sending
module ubc_mem_model #(parameter logic [6:0] DEV = 7'h50) (
  input  wire logic scl,     // Clock line
  input  wire logic sda,     // Data line
  output logic      sda_pull // Pull data low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:15] = '{8'hC4, 8'h5A, 8'h3C, 8'hC4, 8'h06, 8'h00, 8'h34, 8'h12,
    8'h78, 8'h56, 8'hBC, 8'h9A, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] sh = '0, dat = '0;
  logic [3:0] ptr = '0;
  logic       act = 0, rd = 0, adr = 0, mack = 0, drv = 0;
  int         bitn = 0;
  initial sda_pull = 0;
  always @(negedge sda)
    if (scl)
    begin
      act = 1;
      adr = 1;
      bitn = 0;
    end
  always @(posedge sda)
    if (scl)
      act = 0;
  always @(posedge scl)
    if (act)
    begin
      if (bitn < 8)
        sh = {sh[6:0], sda};
      else
        mack = !sda;
      bitn++;
    end
  // Only changes while the clock is low, so it never fakes a start or stop
  always @(negedge scl)
    if (act)
    begin
      sda_pull = 0;
      if (bitn == 8)
      begin
        drv = 0;
        if (adr)
        begin
          rd = sh[0];
          sda_pull = (sh[7:1] == DEV);
          act = sda_pull;
        end
        else if (!rd)
        begin
          ptr = sh[3:0];
          sda_pull = 1;
        end
        adr = 0;
      end
      else if (bitn == 9)
      begin
        bitn = 0;
        drv = rd && mack;
        dat = mem[ptr];
        ptr = ptr + 4'(drv);
        sda_pull = drv && !dat[7];
      end
      else
        sda_pull = drv && !dat[7 - bitn];
    end
endmodule : ubc_mem_model

// file: ubc_chk_props.sv
// Purpose: Port assertions for ubc_boot_irq
// Assumes: Single clock, synchronous active-high reset
// Notes:   Attached by bind at the foot
module ubc_chk (
  input wire logic        sys_clk,             // Clock
  input wire logic        reset,               // Reset
  input wire logic        high_speed,          // Speed
  input wire logic        cmd_rd_req,          // Read request
  input wire logic        slave_read_strobe,   // Read strobe
  input wire logic        slave_output_enable, // Output enable
  input wire logic        int_n,               // Interrupt
  input wire logic        ready_out,           // Data ready
  input wire logic [7:0]  data_bus_low_byte,   // Read data
  input wire logic        usb_connect,         // Attached
  input wire logic        default_desc,        // Built-in descriptor
  input wire logic [10:0] ep_pkt_size,         // Packet size
  input wire logic [3:0]  ep_in_mask           // Directions
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  chk_rd_release: assert property ($rose(slave_read_strobe) && slave_output_enable
    && !int_n |-> ##[1:2] int_n) else $error("interrupt held after read");
  chk_stat_bits: assert property ($rose(slave_read_strobe) && slave_output_enable
    && !int_n && !ready_out |-> ##2 data_bus_low_byte[4:3] == 2'b00 && data_bus_low_byte != 8'h00)
    else $error("bad status byte");
  chk_pkt_hs: assert property (high_speed [*2] |-> ep_pkt_size == 11'h200)
    else $error("packet size");
  chk_in_mask: assert property (ep_in_mask == 4'hC) else $error("direction mask");
  chk_conn_hold: assert property (usb_connect |=> usb_connect) else $error("connect lost");
  chk_dflt_conn: assert property (default_desc |-> usb_connect) else $error("default");
  chk_rd_hold: assert property (cmd_rd_req && int_n |=> (int_n || ready_out) [*3])
    else $error("status shown during read request");
  chk_rd_ready: assert property (cmd_rd_req && int_n |-> ##[1:4] !int_n && ready_out)
    else $error("read data not signalled");
  cover property ($rose(usb_connect));
  cover property ($rose(ready_out));
  cover property ($fell(int_n) && !ready_out);
endmodule : ubc_chk

bind ubc_boot_irq ubc_chk chk_u (.sys_clk, .reset, .high_speed, .cmd_rd_req, .slave_read_strobe,
  .slave_output_enable, .int_n, .ready_out, .data_bus_low_byte, .usb_connect, .default_desc,
  .ep_pkt_size, .ep_in_mask);

// file: tb_top.sv
// Purpose: Self-checking bench for ubc_boot_irq
// Assumes: 40 MHz clock, pulled-up serial lines
// Notes:   Memory boot first, then master boot after a second reset
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, reset = 1, high_speed = 0, cmd_wr = 0, cmd_rd_req = 0;
  logic slave_read_strobe = 0, slave_output_enable = 0, scl, sda, mem_pull;
  logic scl_o, scl_oe, sda_o, sda_oe, int_n, ready_out, data_bus_oe, desc_strobe;
  logic usb_connect, default_desc;
  logic [2:0] memory_strap_bits = 3'h0;
  logic [5:0] cmd_addr = '0;
  logic [7:0] cmd_data = '0, v, data_bus_low_byte, interface_config, flag_polarity, desc_byte;
  logic [10:0] ep_pkt_size;
  logic [3:0] ep_in_mask;
  ubc_pkg::ubc_evt_t usb_evt = '0;
  ubc_pkg::ubc_ids_t id_codes;
  int failures = 0, n_checks = 0, cyc = 0;
  // Open-drain lines with pull-ups
  assign scl = !scl_oe;
  assign sda = !(sda_oe || mem_pull);
  always #12.5 sys_clk = !sys_clk;
  ubc_boot_irq dut_u (.sys_clk, .reset, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o,
    .sda_oe, .memory_strap_bits, .usb_evt, .high_speed, .cmd_wr, .cmd_rd_req, .cmd_addr,
    .cmd_data, .slave_read_strobe, .slave_output_enable, .int_n, .ready_out,
    .data_bus_low_byte, .data_bus_oe, .interface_config, .flag_polarity, .desc_strobe,
    .desc_byte, .usb_connect, .default_desc, .id_codes, .ep_pkt_size, .ep_in_mask);
  ubc_mem_model mem_u (.scl, .sda, .sda_pull(mem_pull));
  task end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      failures++;
      end_sim();
    end
  end
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cmd_addr <= a;
    cmd_data <= d;
    cmd_wr <= 1;
    @(posedge sys_clk);
    cmd_wr <= 0;
  endtask : wr
  task rdq(input logic [5:0] a);
    @(posedge sys_clk);
    cmd_addr <= a;
    cmd_rd_req <= 1;
    @(posedge sys_clk);
    cmd_rd_req <= 0;
  endtask : rdq
  task rd(input logic [7:0] e);
    @(posedge sys_clk);
    slave_read_strobe <= 1;
    slave_output_enable <= 1;
    repeat (3) @(posedge sys_clk);
    #1 v = data_bus_low_byte;
    `CHK(data_bus_oe, 1'b1)
    @(posedge sys_clk);
    slave_read_strobe <= 0;
    slave_output_enable <= 0;
    `CHK(v, e)
  endtask : rd
  task ev(input logic [4:0] e);
    @(posedge sys_clk);
    usb_evt <= e;
    @(posedge sys_clk);
    usb_evt <= '0;
  endtask : ev
  task wait_int(input logic rdy);
    repeat (2) @(posedge sys_clk) #1;
    for (int i = 0; i < 40 && int_n !== 1'b0; i++) @(posedge sys_clk) #1;
    `CHK(int_n, 1'b0)
    `CHK(ready_out, rdy)
  endtask : wait_int
  task t_mem_boot;
    for (int i = 0; i < 75000 && usb_connect !== 1'b1; i++) @(posedge sys_clk) #1;
    `CHK(usb_connect, 1'b1)
    `CHK(interface_config, 8'h5A)
    `CHK(flag_polarity, 8'h3C)
    `CHK(default_desc, 1'b1)
    `CHK(id_codes, 48'h9ABC_5678_1234)
    repeat (5000) @(posedge sys_clk);
    `CHK({scl, sda, scl_o, sda_o}, 4'b1100)
    wr(6'h31, 8'hFF);
    ev(5'h02);
    wait_int(1'b0);
    rd(8'h04);
    rdq(6'h31);
    wait_int(1'b1);
    rd(8'hE7);
  endtask : t_mem_boot
  task t_master_boot;
    @(posedge sys_clk);
    reset <= 1;
    memory_strap_bits <= 3'h2;
    repeat (8) @(posedge sys_clk);
    reset <= 0;
    repeat (20) @(posedge sys_clk);
    wr(6'h30, 8'h06);
    wr(6'h30, 8'h00);
    for (int i = 1; i < 6; i++) wr(6'h30, 8'(i * 17));
    #1 `CHK(usb_connect, 1'b0)
    wr(6'h30, 8'h66);
    repeat (2) @(posedge sys_clk) #1;
    `CHK(usb_connect, 1'b1)
    `CHK(default_desc, 1'b1)
    `CHK(id_codes, 48'h6655_4433_2211)
    @(posedge sys_clk);
    high_speed <= 1;
    repeat (3) @(posedge sys_clk) #1;
    `CHK(ep_pkt_size, 11'h200)
  endtask : t_master_boot
  // Strap 001 addresses a memory that is not fitted, so the probe must fall back to the master
  task t_nack_boot;
    @(posedge sys_clk);
    reset <= 1;
    high_speed <= 0;
    memory_strap_bits <= 3'h1;
    repeat (8) @(posedge sys_clk);
    reset <= 0;
    repeat (4500) @(posedge sys_clk);
    #1 `CHK({scl, sda, usb_connect}, 3'b110)
    wr(6'h30, 8'hF5);
    wr(6'h30, 8'h01);
    wr(6'h30, 8'h02);
    wr(6'h30, 8'h00);
    wr(6'h30, 8'hAB);
    #1 `CHK({desc_strobe, desc_byte}, 9'h1AB)
    wr(6'h30, 8'hCD);
    #1 `CHK({usb_connect, default_desc, desc_strobe}, 3'b101)
  endtask : t_nack_boot
  task t_irq;
    wr(6'h31, 8'hE7);
    ev(5'h11);
    wait_int(1'b0);
    rd(8'h80);
    wait_int(1'b0);
    rd(8'h02);
    rdq(6'h31);
    ev(5'h10);
    wait_int(1'b1);
    rd(8'hE7);
    wait_int(1'b0);
    rd(8'h80);
    wr(6'h31, 8'hA7);
    ev(5'h08);
    repeat (10) @(posedge sys_clk) #1;
    `CHK(int_n, 1'b1)
    ev(5'h04);
    wait_int(1'b0);
    rd(8'h20);
  endtask : t_irq
  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset <= 0;
    t_mem_boot();
    t_master_boot();
    t_nack_boot();
    t_irq();
    end_sim();
  end
endmodule : tb_top
